// [verilog/rts_defines.svh]
// Offsets, function codes, reset values, presets and timing counts of the ramp select block.
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH
// Timing: one setting step of the ramp times is 0.1 s.
`define RTS_CLK_NS 4
`define RTS_TENTH_S_NS 100_000_000
`define RTS_CYC_TENTH (`RTS_TENTH_S_NS / `RTS_CLK_NS)
// Register byte offsets.
`define RTS_OFS_CTRL 8'h00
`define RTS_OFS_STATUS 8'h04
`define RTS_OFS_INT_STAT 8'h08
`define RTS_OFS_INT_MASK 8'h0C
`define RTS_OFS_FREQ_REF 8'h10
`define RTS_OFS_FREQ_OUT 8'h14
`define RTS_OFS_FMAX 8'h18
`define RTS_OFS_SWITCH_FREQ 8'h1C
`define RTS_OFS_JOG_FREQ 8'h20
`define RTS_OFS_JOG_TIMES 8'h24
`define RTS_OFS_ESTOP_TIME 8'h28
`define RTS_OFS_APP 8'h2C
`define RTS_OFS_PRESET_FLAGS 8'h30
`define RTS_OFS_PRESET_VF 8'h34
`define RTS_OFS_CARRIER 8'h38
`define RTS_OFS_ANALOG 8'h3C
`define RTS_OFS_RAMP_BASE 8'h40
`define RTS_OFS_TERM_LO 8'h50
`define RTS_OFS_TERM_HI 8'h54
`define RTS_OFS_SLOT_BASE 8'h80
// Input function codes.
`define RTS_FN_RAMP_BIT0 8'h0A
`define RTS_FN_RAMP_BIT1 8'h1E
`define RTS_FN_ESTOP 8'h0E
`define RTS_FN_BASEBLOCK 8'h0F
// Reset values (frequencies in 0.01 Hz, times in 0.1 s).
`define RTS_RST_RAMP_TIME 16'h0064
`define RTS_RST_JOG_TIME 16'h000A
`define RTS_RST_ESTOP_TIME 16'h0032
`define RTS_RST_FMAX 16'h1770
`define RTS_RST_JOG_FREQ 16'h0258
// Application presets (frequency and voltage in 0.1 units, carrier in 0.1 kHz).
`define RTS_PRE_RAMP_TIME 16'h000A
`define RTS_PRE_MID_FREQ 16'h012C
`define RTS_PRE_MID_VOLT_PUMP 16'h0258
`define RTS_PRE_MID_VOLT_FAN 16'h01F4
`define RTS_PRE_CARRIER 8'h50
`define RTS_PRE_CURVE_F 4'hF
`define RTS_ACCESS_USER 2'h1
`define RTS_GROUP_FIRST 8'h01
`define RTS_GROUP_LAST 8'h18
`endif

// [verilog/rts_pkg.sv]
// Types shared by the ramp select block.
package rts_pkg;
  typedef enum logic [2:0] {RTS_APP_NONE, RTS_APP_PUMP, RTS_APP_RSV2, RTS_APP_FAN, RTS_APP_HVAC,
    RTS_APP_RSV5, RTS_APP_RSV6, RTS_APP_RSV7} rts_app_e;
  typedef enum logic [1:0] {RTS_ST_STOP, RTS_ST_RUN, RTS_ST_ESTOP} rts_state_e;
  typedef struct packed {
    logic [15:0] dec;
    logic [15:0] acc;
  } rts_ramp_pair_s;
  typedef struct packed {
    logic [1:0] access_level;
    logic polarity;
    logic jog;
    logic run;
  } rts_ctrl_s;
  typedef struct packed {
    logic auto_carrier;
    logic stall_decel;
    logic restart;
    logic [3:0] vf_curve;
    logic fwd_only;
    logic [1:0] ctrl_mode;
  } rts_preset_s;
endpackage

// [verilog/rts_ramp_select.sv]
// Ramp time selection, jog, emergency stop and coast logic of a motor drive with an APB slave.
`include "rts_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rts_ramp_select #(
  parameter logic [31:0] CYC_TENTH = `RTS_CYC_TENTH
) (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminals and analog inputs.
  input wire logic [5:0] digital_input_terminal,
  input wire logic [9:0] analog_input_first,
  input wire logic [9:0] analog_input_second,
  // Drive outputs.
  output logic [15:0] freq_out,
  output logic power_output_enable,
  output logic emergency_halt_indication,
  output logic irq
);
  import rts_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  rts_ctrl_s ctrl;
  rts_preset_s preset;
  rts_app_e app;
  rts_state_e state, next_state;
  rts_ramp_pair_s ramp_times [4];
  rts_ramp_pair_s jog_times;
  logic [15:0] slots [16];
  logic [7:0] term_fn [6];
  logic [15:0] freq_ref, fmax, switch_freq, jog_freq, estop_time, mid_freq, mid_volt;
  logic [7:0] carrier;
  logic [2:0] int_stat, int_mask, events;
  logic [9:0] ref_first, ref_second;
  logic [1:0] ramp_set;
  logic [47:0] acc;

  // ****************************************
  // Terminal synchronisers
  // ****************************************
  logic [5:0] din_s1, din_s2, din_s3, din_f;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {din_s3, din_s2, din_s1, din_f} <= 24'h00_0000;
    end else if (ce) begin
      {din_s3, din_s2, din_s1} <= {din_s2, din_s1, digital_input_terminal};
      // A high level counts only once the last two stages agree; a disagreement clears the bit at once.
      din_f <= (din_f & ~(din_s2 ^ din_s3)) | (din_s2 & ~(din_s2 ^ din_s3));
    end
  end

  function automatic logic [5:0] fn_match(input logic [7:0] code);
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 6; i++) begin
      m[i] = (term_fn[i] == code);
    end
    return m;
  endfunction
  logic [5:0] m_b0, m_b1;
  logic bit0_act, bit1_act, dig_used, estop_act, bb_act;
  assign m_b0 = fn_match(`RTS_FN_RAMP_BIT0);
  assign m_b1 = fn_match(`RTS_FN_RAMP_BIT1);
  assign bit0_act = |(m_b0 & din_f);
  assign bit1_act = |(m_b1 & din_f);
  assign dig_used = |(m_b0 | m_b1);
  assign estop_act = |(fn_match(`RTS_FN_ESTOP) & din_f);
  assign bb_act = |(fn_match(`RTS_FN_BASEBLOCK) & din_f);

  // ****************************************
  // Ramp set selection and drive state
  // ****************************************
  logic [1:0] next_set;
  assign next_set = dig_used ? {bit1_act, bit0_act} :
    (switch_freq != 16'h0000 && freq_out >= switch_freq) ? 2'h3 : 2'h0;
  always_comb begin
    case (state)
      RTS_ST_STOP: next_state = (ctrl.run || ctrl.jog) ? RTS_ST_RUN : RTS_ST_STOP;
      RTS_ST_RUN: next_state = (!ctrl.run && !ctrl.jog && freq_out == 16'h0000) ? RTS_ST_STOP : RTS_ST_RUN;
      // The stop stays latched until the run and jog commands and the input are all gone.
      RTS_ST_ESTOP: next_state = (!ctrl.run && !ctrl.jog && !estop_act) ? RTS_ST_STOP : RTS_ST_ESTOP;
      default: next_state = RTS_ST_STOP;
    endcase
    if (estop_act) begin
      next_state = RTS_ST_ESTOP;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RTS_ST_STOP;
      ramp_set <= 2'h0;
      {emergency_halt_indication, power_output_enable} <= 2'h0;
    end else if (ce) begin
      state <= next_state;
      ramp_set <= next_set;
      emergency_halt_indication <= (next_state == RTS_ST_ESTOP);
      power_output_enable <= !bb_act && (next_state != RTS_ST_STOP);
    end
  end

  // ****************************************
  // Ramp generator and analog reference polarity
  // ****************************************
  logic [15:0] target, raw_target, ramp_time;
  logic [47:0] thr, acc_sum;
  logic going_up;
  always_comb begin
    raw_target = (state == RTS_ST_RUN && ctrl.jog) ? jog_freq :
      (state == RTS_ST_RUN && ctrl.run) ? freq_ref : 16'h0000;
    target = (raw_target > fmax) ? fmax : raw_target;
    going_up = target > freq_out;
    ramp_time = (state == RTS_ST_ESTOP) ? estop_time :
      ctrl.jog ? (going_up ? jog_times.acc : jog_times.dec) :
      going_up ? ramp_times[ramp_set].acc : ramp_times[ramp_set].dec;
  end
  // Each step is 0.01 Hz, so accumulating fmax per cycle against the span in cycles keeps the rate exact.
  assign thr = 48'(ramp_time) * 48'(CYC_TENTH);
  assign acc_sum = acc + {32'h0000_0000, fmax};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_out <= 16'h0000;
      acc <= 48'h0000_0000_0000;
    end else if (ce) begin
      if (bb_act) begin
        freq_out <= 16'h0000;
        acc <= 48'h0000_0000_0000;
      end else if (freq_out == target) begin
        acc <= 48'h0000_0000_0000;
      end else if (thr == 48'h0000_0000_0000) begin
        freq_out <= target;
      end else if (acc_sum >= thr) begin
        freq_out <= going_up ? freq_out + 16'h0001 : freq_out - 16'h0001;
        acc <= acc_sum - thr;
      end else begin
        acc <= acc_sum;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ref_second, ref_first} <= 20'h0_0000;
    end else if (ce) begin
      ref_first <= ctrl.polarity ? ~analog_input_first : analog_input_first;
      ref_second <= ctrl.polarity ? ~analog_input_second : analog_input_second;
    end
  end
  // ****************************************
  // APB slave
  // ****************************************
  logic setup, wr_ok, slot_hit, slot_ok, idle, rd_err;
  logic [3:0] slot_idx;
  logic [31:0] rd_data;
  assign setup = psel && !penable;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr && ce;
  assign slot_hit = paddr[7:6] == 2'h2 && paddr[1:0] == 2'h0;
  assign slot_idx = paddr[5:2];
  assign idle = state == RTS_ST_STOP && freq_out == 16'h0000;
  // Slots take only user level, a stopped drive and a group in range.
  assign slot_ok = ctrl.access_level == `RTS_ACCESS_USER && idle && pwdata[15:8] >= `RTS_GROUP_FIRST &&
    pwdata[15:8] <= `RTS_GROUP_LAST;
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `RTS_OFS_CTRL: rd_data = {27'h000_0000, ctrl};
      `RTS_OFS_STATUS: rd_data = {26'h000_0000, power_output_enable, bb_act, state == RTS_ST_RUN,
        state == RTS_ST_ESTOP, ramp_set};
      `RTS_OFS_INT_STAT: rd_data = {29'h0000_0000, int_stat};
      `RTS_OFS_INT_MASK: rd_data = {29'h0000_0000, int_mask};
      `RTS_OFS_FREQ_REF: rd_data = {16'h0000, freq_ref};
      `RTS_OFS_FREQ_OUT: rd_data = {16'h0000, freq_out};
      `RTS_OFS_FMAX: rd_data = {16'h0000, fmax};
      `RTS_OFS_SWITCH_FREQ: rd_data = {16'h0000, switch_freq};
      `RTS_OFS_JOG_FREQ: rd_data = {16'h0000, jog_freq};
      `RTS_OFS_JOG_TIMES: rd_data = jog_times;
      `RTS_OFS_ESTOP_TIME: rd_data = {16'h0000, estop_time};
      `RTS_OFS_APP: rd_data = {29'h0000_0000, app};
      `RTS_OFS_PRESET_FLAGS: rd_data = {22'h00_0000, preset};
      `RTS_OFS_PRESET_VF: rd_data = {mid_volt, mid_freq};
      `RTS_OFS_CARRIER: rd_data = {24'h00_0000, carrier};
      `RTS_OFS_ANALOG: rd_data = {6'h00, ref_second, 6'h00, ref_first};
      `RTS_OFS_TERM_LO: rd_data = {term_fn[3], term_fn[2], term_fn[1], term_fn[0]};
      `RTS_OFS_TERM_HI: rd_data = {16'h0000, term_fn[5], term_fn[4]};
      default: begin
        if (paddr[7:4] == 4'h4 && paddr[1:0] == 2'h0) begin
          rd_data = ramp_times[paddr[3:2]];
        end else if (slot_hit) begin
          // Slots read as zero outside user level.
          rd_data = (ctrl.access_level == `RTS_ACCESS_USER) ? {16'h0000, slots[slot_idx]} : 32'h0000_0000;
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
    rd_err = rd_err || (pwrite && slot_hit && !slot_ok);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pready, pslverr} <= 2'h0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup && rd_err;
      prdata <= (setup && !pwrite && !rd_err) ? rd_data : 32'h0000_0000;
    end
  end
  // ****************************************
  // Configuration registers, slots and interrupts
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      freq_ref <= 16'h0000;
      fmax <= `RTS_RST_FMAX;
      switch_freq <= 16'h0000;
      jog_freq <= `RTS_RST_JOG_FREQ;
      jog_times <= {`RTS_RST_JOG_TIME, `RTS_RST_JOG_TIME};
      estop_time <= `RTS_RST_ESTOP_TIME;
      int_mask <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        term_fn[i] <= 8'h00;
      end
    end else if (wr_ok) begin
      case (paddr)
        `RTS_OFS_CTRL: ctrl <= pwdata[4:0];
        `RTS_OFS_INT_MASK: int_mask <= pwdata[2:0];
        `RTS_OFS_FREQ_REF: freq_ref <= pwdata[15:0];
        `RTS_OFS_FMAX: fmax <= pwdata[15:0];
        `RTS_OFS_SWITCH_FREQ: switch_freq <= pwdata[15:0];
        `RTS_OFS_JOG_FREQ: jog_freq <= pwdata[15:0];
        `RTS_OFS_JOG_TIMES: jog_times <= pwdata;
        `RTS_OFS_ESTOP_TIME: estop_time <= pwdata[15:0];
        `RTS_OFS_TERM_LO: {term_fn[3], term_fn[2], term_fn[1], term_fn[0]} <= pwdata;
        `RTS_OFS_TERM_HI: {term_fn[5], term_fn[4]} <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  // Ramp times share a process with the application loader, which overwrites set one for the pump application.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app <= RTS_APP_NONE;
      preset <= '0;
      {mid_volt, mid_freq} <= 32'h0000_0000;
      carrier <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        ramp_times[i] <= {`RTS_RST_RAMP_TIME, `RTS_RST_RAMP_TIME};
      end
    end else if (wr_ok) begin
      if (paddr[7:4] == 4'h4 && paddr[1:0] == 2'h0) begin
        ramp_times[paddr[3:2]] <= pwdata;
      end else if (paddr == `RTS_OFS_APP) begin
        app <= rts_app_e'(pwdata[2:0]);
        case (rts_app_e'(pwdata[2:0]))
          RTS_APP_PUMP: begin
            preset <= '{1'b0, 1'b1, 1'b1, `RTS_PRE_CURVE_F, 1'b1, 2'h0};
            ramp_times[0] <= {`RTS_PRE_RAMP_TIME, `RTS_PRE_RAMP_TIME};
            mid_freq <= `RTS_PRE_MID_FREQ;
            mid_volt <= `RTS_PRE_MID_VOLT_PUMP;
          end
          RTS_APP_FAN: begin
            preset <= '{1'b0, 1'b1, 1'b1, `RTS_PRE_CURVE_F, 1'b1, 2'h0};
            mid_freq <= `RTS_PRE_MID_FREQ;
            mid_volt <= `RTS_PRE_MID_VOLT_FAN;
          end
          RTS_APP_HVAC: begin
            preset <= '{1'b1, preset.stall_decel, 1'b1, preset.vf_curve, 1'b1, 2'h0};
            carrier <= `RTS_PRE_CARRIER;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_ok && slot_hit) begin
      slots[slot_idx] <= pwdata[15:0];
    end
  end
  logic bb_prev, reached_prev, reached;
  assign reached = freq_out == target && target != 16'h0000;
  assign events = {reached && !reached_prev, bb_act && !bb_prev, next_state == RTS_ST_ESTOP && state != RTS_ST_ESTOP};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= 3'h0;
      {bb_prev, reached_prev} <= 2'h0;
      irq <= 1'b0;
    end else if (ce) begin
      bb_prev <= bb_act;
      reached_prev <= reached;
      // A new event wins over a clear in the same cycle.
      int_stat <= (int_stat & ~((wr_ok && paddr == `RTS_OFS_INT_STAT) ? pwdata[2:0] : 3'h0)) | events;
      irq <= |(int_stat & int_mask);
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_slot_wr_busy;
    psel && !penable && pwrite && slot_hit && !idle && ce;
  endsequence
  sequence s_err_answer;
    pready && pslverr;
  endsequence
  chk_set_digital: assert property (ce && dig_used |=> ramp_set == $past({bit1_act, bit0_act}))
    else $error("Input-selected ramp set not applied.");
  chk_auto_disabled: assert property (ce && !dig_used && switch_freq == 16'h0000 |=> ramp_set == 2'h0)
    else $error("Automatic switch-over active with zero threshold.");
  chk_auto_high: assert property (ce && !dig_used && switch_freq != 16'h0000 && freq_out >= switch_freq
    |=> ramp_set == 2'h3)
    else $error("Set four not applied above threshold.");
  chk_jog_target: assert property (state == RTS_ST_RUN && ctrl.jog && jog_freq <= fmax |-> target == jog_freq)
    else $error("Jog frequency not used as reference.");
  chk_estop_entry: assert property (ce && estop_act |=> state == RTS_ST_ESTOP && emergency_halt_indication)
    else $error("Emergency stop not latched.");
  chk_estop_hold: assert property (ce && state == RTS_ST_ESTOP && (ctrl.run || estop_act) |=> state == RTS_ST_ESTOP)
    else $error("Emergency stop released too early.");
  chk_coast_off: assert property (ce && bb_act |=> !power_output_enable && freq_out == 16'h0000)
    else $error("Output not cut on base block.");
  chk_ramp_rate: assert property (ce && !bb_act && thr != 48'h0000_0000_0000 |=>
    (freq_out - $past(freq_out) == 16'h0001) || ($past(freq_out) - freq_out == 16'h0001) ||
    freq_out == $past(freq_out))
    else $error("Ramp moved more than one step.");
  chk_slot_busy: assert property (s_slot_wr_busy |=> s_err_answer ##1 slots[$past(slot_idx, 2)] ==
    $past(slots[slot_idx], 2))
    else $error("Slot edit accepted while running.");
endmodule // rts_ramp_select
`default_nettype wire

// [testbench/rts_terminal_model.sv]
// Model of the terminal strip and analog sources that feed the ramp select block.
`timescale 1ns/1ps
`default_nettype none
module rts_terminal_model (
  // Clock.
  input wire logic pclk,
  // Operator requests.
  input wire logic [5:0] close_req,
  input wire logic [9:0] level_first,
  input wire logic [9:0] level_second,
  // Levels at the block.
  output logic [5:0] digital_input_terminal = 6'h00,
  output logic [9:0] analog_input_first = 10'h000,
  output logic [9:0] analog_input_second = 10'h000
);
  // ****************************************************************
  // Contacts and converters
  // ****************************************************************
  // Contacts move just after an edge; bounce is left out because the block filters it anyway.
  always @(posedge pclk) begin
    digital_input_terminal <= close_req;
    analog_input_first <= level_first;
    analog_input_second <= level_second;
  end
endmodule // rts_terminal_model
`default_nettype wire

// [testbench/rts_ramp_select_bench.sv]
// Self-checking bench of the ramp select block.
`include "rts_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rts_ramp_select_bench;
  import rts_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [5:0] close_req = 6'h00;
  logic [9:0] lv1 = 10'h000;
  logic [9:0] lv2 = 10'h000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, pwr_en, halt, irq;
  logic [5:0] term;
  logic [9:0] ain1, ain2;
  logic [15:0] freq_out;
  rts_preset_s pre;
  int mismatches = 0;
  int compares = 0;
  rts_ramp_select #(.CYC_TENTH(32'h0000_000A)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digital_input_terminal(term), .analog_input_first(ain1), .analog_input_second(ain2),
    .freq_out(freq_out), .power_output_enable(pwr_en), .emergency_halt_indication(halt), .irq(irq));
  rts_terminal_model PARTNER (.pclk(pclk), .close_req(close_req), .level_first(lv1), .level_second(lv2),
    .digital_input_terminal(term), .analog_input_first(ain1), .analog_input_second(ain2));
  initial begin
    forever #2 pclk = ~pclk;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // An idle edge follows each transfer so that psel is never driven twice in one time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the answer.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat & m, e);
  endtask
  task automatic wait_freq(input logic [15:0] v, input int lim);
    int n;
    n = 0;
    while (freq_out !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({16'h0000, freq_out}, {16'h0000, v});
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_reset();
    rdchk(`RTS_OFS_FMAX, 32'h0000_FFFF, {16'h0000, `RTS_RST_FMAX});
    rdchk(`RTS_OFS_JOG_FREQ, 32'h0000_FFFF, {16'h0000, `RTS_RST_JOG_FREQ});
    rdchk(`RTS_OFS_JOG_TIMES, 32'hFFFF_FFFF, {`RTS_RST_JOG_TIME, `RTS_RST_JOG_TIME});
    rdchk(`RTS_OFS_ESTOP_TIME, 32'h0000_FFFF, {16'h0000, `RTS_RST_ESTOP_TIME});
    rdchk(`RTS_OFS_RAMP_BASE, 32'hFFFF_FFFF, {`RTS_RST_RAMP_TIME, `RTS_RST_RAMP_TIME});
    rdchk(`RTS_OFS_SWITCH_FREQ, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
  endtask
  task automatic s_jog();
    wr(`RTS_OFS_CTRL, 32'h0000_0002);
    wait_freq(`RTS_RST_JOG_FREQ, 3000);
    wr(`RTS_OFS_CTRL, 32'h0000_0000);
    wait_freq(16'h0000, 3000);
  endtask
  // Four cycles per step: fmax 10.00 Hz against a 40.0 s ramp at ten cycles a tenth.
  task automatic s_rate();
    wr(`RTS_OFS_FMAX, 32'h0000_03E8);
    wr(`RTS_OFS_RAMP_BASE, 32'h0190_0190);
    wr(`RTS_OFS_FREQ_REF, 32'h0000_0064);
    wr(`RTS_OFS_CTRL, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    chk(32'(freq_out >= 16'h002D && freq_out <= 16'h0037), 32'h0000_0001);
    wait_freq(16'h0064, 800);
  endtask
  task automatic s_auto();
    wr(`RTS_OFS_RAMP_BASE, 32'h0000_0000);
    wr(`RTS_OFS_RAMP_BASE + 8'h0C, 32'h0000_0000);
    wr(`RTS_OFS_FREQ_REF, 32'h0000_0320);
    repeat (10) @(posedge pclk);
    rdchk(`RTS_OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
    wr(`RTS_OFS_SWITCH_FREQ, 32'h0000_01F4);
    rdchk(`RTS_OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
    wr(`RTS_OFS_FREQ_REF, 32'h0000_01F4);
    repeat (10) @(posedge pclk);
    rdchk(`RTS_OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
    wr(`RTS_OFS_FREQ_REF, 32'h0000_01F3);
    repeat (10) @(posedge pclk);
    rdchk(`RTS_OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
  endtask
  task automatic s_term();
    wr(`RTS_OFS_FREQ_REF, 32'h0000_0320);
    wr(`RTS_OFS_TERM_LO, {16'h0000, `RTS_FN_RAMP_BIT1, `RTS_FN_RAMP_BIT0});
    for (int i = 0; i < 4; i++) begin
      close_req <= 6'(i);
      repeat (10) @(posedge pclk);
      rdchk(`RTS_OFS_STATUS, 32'h0000_0003, 32'(i));
    end
  endtask
  task automatic s_estop();
    wr(`RTS_OFS_TERM_LO, {`RTS_FN_BASEBLOCK, `RTS_FN_ESTOP, 16'h0000});
    wr(`RTS_OFS_INT_MASK, 32'h0000_0001);
    wr(`RTS_OFS_ESTOP_TIME, 32'h0000_00C8);
    close_req <= 6'h04;
    repeat (10) @(posedge pclk);
    chk({31'h0, halt}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    repeat (400) @(posedge pclk);
    chk(32'(freq_out >= 16'h0249 && freq_out <= 16'h0262), 32'h0000_0001);
    wait_freq(16'h0000, 2000);
    close_req <= 6'h00;
    repeat (10) @(posedge pclk);
    chk({31'h0, halt}, 32'h0000_0001);
    rdchk(`RTS_OFS_INT_STAT, 32'h0000_0001, 32'h0000_0001);
    wr(`RTS_OFS_INT_STAT, 32'h0000_0001);
    rdchk(`RTS_OFS_INT_STAT, 32'h0000_0001, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`RTS_OFS_CTRL, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    chk({31'h0, halt}, 32'h0000_0000);
    wr(`RTS_OFS_CTRL, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    chk({31'h0, pwr_en}, 32'h0000_0001);
  endtask
  task automatic s_coast();
    wr(`RTS_OFS_INT_MASK, 32'h0000_0002);
    close_req <= 6'h08;
    repeat (8) @(posedge pclk);
    chk({31'h0, pwr_en}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    close_req <= 6'h00;
    repeat (10) @(posedge pclk);
    chk({31'h0, pwr_en}, 32'h0000_0001);
    wr(`RTS_OFS_INT_STAT, 32'h0000_0007);
    // The interrupt output lags the status bits by one register stage.
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask
  task automatic s_polar();
    wr(`RTS_OFS_CTRL, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    rdchk(`RTS_OFS_ANALOG, 32'h03FF_03FF, 32'h0000_0000);
    wr(`RTS_OFS_CTRL, 32'h0000_0004);
    lv1 <= 10'h3FF;
    lv2 <= 10'h3FF;
    repeat (4) @(posedge pclk);
    rdchk(`RTS_OFS_ANALOG, 32'h03FF_03FF, 32'h0000_0000);
    lv1 <= 10'h000;
    repeat (4) @(posedge pclk);
    rdchk(`RTS_OFS_ANALOG, 32'h03FF_03FF, 32'h0000_03FF);
  endtask
  task automatic s_app();
    pre = '{1'b0, 1'b1, 1'b1, `RTS_PRE_CURVE_F, 1'b1, 2'b00};
    wr(`RTS_OFS_APP, 32'h0000_0001);
    rdchk(`RTS_OFS_PRESET_FLAGS, 32'h0000_03FF, {22'h0, pre});
    rdchk(`RTS_OFS_PRESET_VF, 32'hFFFF_FFFF, {`RTS_PRE_MID_VOLT_PUMP, `RTS_PRE_MID_FREQ});
    rdchk(`RTS_OFS_RAMP_BASE, 32'hFFFF_FFFF, {`RTS_PRE_RAMP_TIME, `RTS_PRE_RAMP_TIME});
    wr(`RTS_OFS_APP, 32'h0000_0003);
    rdchk(`RTS_OFS_PRESET_FLAGS, 32'h0000_03FF, {22'h0, pre});
    rdchk(`RTS_OFS_PRESET_VF, 32'hFFFF_FFFF, {`RTS_PRE_MID_VOLT_FAN, `RTS_PRE_MID_FREQ});
    wr(`RTS_OFS_APP, 32'h0000_0004);
    rdchk(`RTS_OFS_PRESET_FLAGS, 32'h0000_0287, 32'h0000_0284);
    rdchk(`RTS_OFS_CARRIER, 32'h0000_00FF, {24'h0, `RTS_PRE_CARRIER});
    wr(`RTS_OFS_APP, 32'h0000_0002);
    rdchk(`RTS_OFS_APP, 32'h0000_0007, 32'h0000_0002);
  endtask
  task automatic s_slot();
    logic [7:0] sa [4] = '{8'h80, 8'hBC, 8'h84, 8'h88};
    logic [31:0] sd [4] = '{32'h0000_0301, 32'h0000_1805, 32'h0000_1900, 32'h0000_0007};
    logic se [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    wr(`RTS_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, 8'h80, 32'h0000_0301);
    chk({31'h0, rerr}, 32'h0000_0001);
    wr(`RTS_OFS_CTRL, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, sa[i], sd[i]);
      chk({31'h0, rerr}, {31'h0, se[i]});
    end
    rdchk(8'h80, 32'h0000_FFFF, 32'h0000_0301);
    rdchk(8'hBC, 32'h0000_FFFF, 32'h0000_1805);
    wr(`RTS_OFS_CTRL, 32'h0000_0000);
    rdchk(8'hBC, 32'h0000_FFFF, 32'h0000_0000);
    wr(`RTS_OFS_CTRL, 32'h0000_0009);
    repeat (10) @(posedge pclk);
    apb(1'b1, 8'h84, 32'h0000_0502);
    chk({31'h0, rerr}, 32'h0000_0001);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_jog();
    s_rate();
    s_auto();
    s_term();
    s_estop();
    s_coast();
    s_polar();
    s_app();
    s_slot();
    finish_test();
  end
  // The scenarios need some 4000 cycles; this limit leaves ample margin.
  initial begin
    #400_000;
    mismatches++;
    finish_test();
  end
endmodule // rts_ramp_select_bench
`default_nettype wire
